// *** ascr_top.sv ***
// scan configuration and result register bank with scan sequencer
`timescale 1ns/1ps
module ascr_top
    import ascr_pkg::*;
#(
    parameter int CONV_DIV = CONV_DIV_DEFAULT
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scanStart,
    input wire logic convDone,
    input wire logic [11:0] convData,
    input wire logic calLaunch,
    input wire logic calDone,
    input wire logic [5:0] calResult,
    output logic scanBusy,
    output logic sampling,
    output logic [4:0] sampleChannel,
    output logic convStart,
    output logic [5:0] calFactorApplied,
    output logic irq
);
    typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_SAMPLE, ST_CONVERT} ascr_scan_e;

    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [31:0] sampleSel_q, sampleSel_d, scanMask_q, scanMask_d;
    logic [31:0] wdgMask_q, wdgMask_d, wdgThr_q, wdgThr_d;
    logic [31:0] cal_factor_q, cal_factor_d, result_q, result_d;
    logic [3:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
    logic irq_q, irq_d;
    logic [5:0] calApplied_q, calApplied_d;
    logic awTake, wTake, arTake, doWrite, awPre, wPre;
    logic [31:0] byteMask;
    logic [31:0] maskMerge;
    logic [32:0] rdWord;

    ascr_scan_e state_q, state_d;
    logic [4:0] idx_q, idx_d;
    logic [10:0] sampCnt_q, sampCnt_d;
    logic [7:0] divCnt_q, divCnt_d;
    logic convClkEn_q, convClkEn_d;
    logic convStart_q, convStart_d, sampling_q, sampling_d, busy_q, busy_d;
    logic evWdg, evSampEnd, evScanEnd, resultLoad;
    logic [10:0] firstCycles, secondCycles, curDur;
    logic [NUM_CHAN-1:0] selVec, chanSel, wdgSel;
    logic outside;
    logic wdgWatched;

    ascr_sample_decode u_first_decode (
        .code(sampleSel_q[FIRST_CODE_LSB +: 4]),
        .cycles(firstCycles)
    );

    ascr_sample_decode u_second_decode (
        .code(sampleSel_q[SECOND_CODE_LSB +: 4]),
        .cycles(secondCycles)
    );

    ascr_limit_check u_limit (
        .value(convData),
        .lower(wdgThr_q[11:0]),
        .upper(wdgThr_q[UPPER_LSB +: 12]),
        .outside(outside)
    );

    // merge a strobed write into a register under its writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [31:0] bm, input logic [31:0] wm);
        merge = (old & ~(bm & wm)) | (data & bm & wm);
    endfunction

    // read decode with error flag on top
    function automatic logic [32:0] readReg(input logic [7:0] a);
        case ({a[7:2], 2'h0})
            SAMPLE_SEL_OFS: readReg = {1'h0, sampleSel_q};
            SCAN_MASK_OFS: readReg = {1'h0, scanMask_q};
            WDG_MASK_OFS: readReg = {1'h0, wdgMask_q};
            WDG_THR_OFS: readReg = {1'h0, wdgThr_q};
            CAL_FACT_OFS: readReg = {1'h0, cal_factor_q};
            RESULT_OFS: readReg = {1'h0, result_q};
            IRQ_STAT_OFS: readReg = {29'h0, irqStat_q};
            IRQ_MASK_OFS: readReg = {29'h0, irqMask_q};
            default: readReg = {1'h1, 32'h0};
        endcase
    endfunction

    // bus slave and register file
    always_comb
    begin
        awTake = s_axi_awvalid && awready_q;
        wTake = s_axi_wvalid && wready_q;
        arTake = s_axi_arvalid && arready_q;
        awAddr_d = awTake ? s_axi_awaddr : awAddr_q;
        wData_d = wTake ? s_axi_wdata : wData_q;
        wStrb_d = wTake ? s_axi_wstrb : wStrb_q;
        awPre = awHeld_q || awTake;
        wPre = wHeld_q || wTake;
        doWrite = awPre && wPre && !bvalid_q;
        awHeld_d = awPre && !doWrite;
        wHeld_d = wPre && !doWrite;
        for (int i = 0; i < 4; i++)
        begin
            byteMask[8*i +: 8] = {8{wStrb_d[i]}};
        end
        maskMerge = merge({28'h0, irqMask_q}, wData_d, byteMask, IRQ_WMASK);
        sampleSel_d = sampleSel_q;
        scanMask_d = scanMask_q;
        wdgMask_d = wdgMask_q;
        wdgThr_d = wdgThr_q;
        cal_factor_d = cal_factor_q;
        result_d = result_q;
        irqMask_d = irqMask_q;
        irqStat_d = irqStat_q;
        bresp_d = bresp_q;
        if (doWrite)
        begin
            bresp_d = RESP_OKAY;
            case ({awAddr_d[7:2], 2'h0})
                SAMPLE_SEL_OFS: sampleSel_d = merge(sampleSel_q, wData_d, byteMask,
                                                    SAMPLE_SEL_WMASK);
                SCAN_MASK_OFS: scanMask_d = merge(scanMask_q, wData_d, byteMask, CHAN_WMASK);
                WDG_MASK_OFS: wdgMask_d = merge(wdgMask_q, wData_d, byteMask, CHAN_WMASK);
                WDG_THR_OFS: wdgThr_d = merge(wdgThr_q, wData_d, byteMask, WDG_THR_WMASK);
                CAL_FACT_OFS: cal_factor_d = merge(cal_factor_q, wData_d, byteMask, CAL_WMASK);
                RESULT_OFS: result_d = result_q;
                IRQ_STAT_OFS: irqStat_d = irqStat_q & ~(wData_d[3:0] & byteMask[3:0]);
                IRQ_MASK_OFS: irqMask_d = maskMerge[3:0];
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (resultLoad)
        begin
            result_d = {20'h0, convData};
        end
        if (calDone)
        begin
            cal_factor_d = {26'h0, calResult};
            result_d = {26'h0, calResult};
        end
        calApplied_d = calLaunch ? cal_factor_q[5:0] : calApplied_q;
        irqStat_d[IRQ_WDG] = irqStat_d[IRQ_WDG] | evWdg;
        irqStat_d[IRQ_SAMPLE_END] = irqStat_d[IRQ_SAMPLE_END] | evSampEnd;
        irqStat_d[IRQ_SCAN_END] = irqStat_d[IRQ_SCAN_END] | evScanEnd;
        irqStat_d[IRQ_CAL_END] = irqStat_d[IRQ_CAL_END] | calDone;
        irq_d = |(irqStat_d & irqMask_d);
        bvalid_d = doWrite || (bvalid_q && !s_axi_bready);
        awready_d = !awHeld_d && !bvalid_d;
        wready_d = !wHeld_d && !bvalid_d;
        rdWord = readReg(s_axi_araddr);
        rdata_d = arTake ? rdWord[31:0] : rdata_q;
        rresp_d = arTake ? (rdWord[32] ? RESP_SLVERR : RESP_OKAY) : rresp_q;
        rvalid_d = arTake || (rvalid_q && !s_axi_rready);
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awready_q <= 1'h0;
            wready_q <= 1'h0;
            bvalid_q <= 1'h0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'h0;
            rvalid_q <= 1'h0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
            awHeld_q <= 1'h0;
            wHeld_q <= 1'h0;
            awAddr_q <= 8'h0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            sampleSel_q <= SAMPLE_SEL_RST;
            scanMask_q <= SCAN_MASK_RST;
            wdgMask_q <= WDG_MASK_RST;
            wdgThr_q <= WDG_THR_RST;
            cal_factor_q <= CAL_FACT_RST;
            result_q <= RESULT_RST;
            irqStat_q <= IRQ_RST;
            irqMask_q <= IRQ_RST;
            irq_q <= 1'h0;
            calApplied_q <= 6'h0;
        end
        else
        begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            sampleSel_q <= sampleSel_d;
            scanMask_q <= scanMask_d;
            wdgMask_q <= wdgMask_d;
            wdgThr_q <= wdgThr_d;
            cal_factor_q <= cal_factor_d;
            result_q <= result_d;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            irq_q <= irq_d;
            calApplied_q <= calApplied_d;
        end
    end

    // scan sequencer and converter clock divider
    always_comb
    begin
        selVec = {sampleSel_q[SEL_CH19_BIT], 2'h0, sampleSel_q[SEL_LOW_MSB:SEL_LOW_LSB]};
        chanSel = scanMask_q[NUM_CHAN-1:0];
        wdgSel = wdgMask_q[NUM_CHAN-1:0];
        wdgWatched = wdgSel[idx_q];
        curDur = selVec[idx_q] ? secondCycles : firstCycles;
        convClkEn_d = (divCnt_q == 8'(CONV_DIV - 1));
        divCnt_d = convClkEn_d ? 8'h0 : 8'(divCnt_q + 8'h01);
        state_d = state_q;
        idx_d = idx_q;
        sampCnt_d = sampCnt_q;
        convStart_d = 1'h0;
        evWdg = 1'h0;
        evSampEnd = 1'h0;
        evScanEnd = 1'h0;
        resultLoad = 1'h0;
        case (state_q)
            ST_IDLE:
            begin
                if (scanStart)
                begin
                    idx_d = 5'h0;
                    state_d = ST_SEEK;
                end
            end
            ST_SEEK:
            begin
                if (chanSel[idx_q])
                begin
                    sampCnt_d = curDur;
                    state_d = ST_SAMPLE;
                end
                else if (idx_q == LAST_CHAN)
                begin
                    evScanEnd = 1'h1;
                    state_d = ST_IDLE;
                end
                else
                begin
                    idx_d = 5'(idx_q + 5'h01);
                end
            end
            ST_SAMPLE:
            begin
                if (convClkEn_q)
                begin
                    if (sampCnt_q == 11'h001)
                    begin
                        convStart_d = 1'h1;
                        evSampEnd = 1'h1;
                        state_d = ST_CONVERT;
                    end
                    else
                    begin
                        sampCnt_d = 11'(sampCnt_q - 11'h001);
                    end
                end
            end
            ST_CONVERT:
            begin
                if (convDone)
                begin
                    resultLoad = 1'h1;
                    evWdg = wdgSel[idx_q] && outside;
                    if (idx_q == LAST_CHAN)
                    begin
                        evScanEnd = 1'h1;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        idx_d = 5'(idx_q + 5'h01);
                        state_d = ST_SEEK;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = (state_d != ST_IDLE);
        sampling_d = (state_d == ST_SAMPLE);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            idx_q <= 5'h0;
            sampCnt_q <= 11'h0;
            divCnt_q <= 8'h0;
            convClkEn_q <= 1'h0;
            convStart_q <= 1'h0;
            sampling_q <= 1'h0;
            busy_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            sampCnt_q <= sampCnt_d;
            divCnt_q <= divCnt_d;
            convClkEn_q <= convClkEn_d;
            convStart_q <= convStart_d;
            sampling_q <= sampling_d;
            busy_q <= busy_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign scanBusy = busy_q;
    assign sampling = sampling_q;
    assign sampleChannel = idx_q;
    assign convStart = convStart_q;
    assign calFactorApplied = calApplied_q;
    assign irq = irq_q;

    // checking helper: enables seen in the current sampling phase
    logic [10:0] enSeen_q;
    always_ff @(posedge clk)
    begin
        if (srst || state_q != ST_SAMPLE)
            enSeen_q <= 11'h0;
        else if (convClkEn_q)
            enSeen_q <= 11'(enSeen_q + 11'h001);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sample_len_a: assert property ((state_q == ST_SAMPLE && convClkEn_q && sampCnt_q == 11'h001)
        |-> enSeen_q + 11'h001 == curDur) else $error("sampling length wrong");
    code_select_a: assert property ($rose(sampling_q) |-> sampCnt_q ==
        (selVec[idx_q] ? secondCycles : firstCycles)) else $error("code select wrong");
    reserved_code_a: assert property (sampleSel_q[FIRST_CODE_LSB +: 4] == 4'h0
        |-> firstCycles == 11'h003) else $error("reserved code not 3");
    long_code_a: assert property (sampleSel_q[SECOND_CODE_LSB +: 4] == 4'hf
        |-> secondCycles == 11'h77f) else $error("longest code wrong");
    skip_unselected_a: assert property (state_q == ST_SAMPLE |-> chanSel[idx_q])
        else $error("unselected channel sampled");
    thr_reset_a: assert property ($fell(srst) |-> wdgThr_q == WDG_THR_RST)
        else $error("threshold reset wrong");
    reserved_zero_a: assert property (((scanMask_q | wdgMask_q) & ~CHAN_WMASK) == 32'h0
        && (wdgThr_q & ~WDG_THR_WMASK) == 32'h0 && (cal_factor_q & ~CAL_WMASK) == 32'h0)
        else $error("reserved bit set");
    cal_update_a: assert property (calDone |=> cal_factor_q[5:0] == $past(calResult)
        && result_q == {26'h0, $past(calResult)}) else $error("calibration copy wrong");
    cal_apply_a: assert property (!calLaunch ##1 !calLaunch |-> $stable(calApplied_q))
        else $error("factor applied without launch");
    wdg_set_a: assert property ((state_q == ST_CONVERT && convDone && wdgSel[idx_q] && outside)
        |=> irqStat_q[IRQ_WDG]) else $error("watchdog flag missed");
    wdg_cause_a: assert property ($rose(irqStat_q[IRQ_WDG]) |-> $past(state_q) == ST_CONVERT
        && $past(convDone) && $past(wdgWatched))
        else $error("watchdog flag without cause");
    irq_level_a: assert property (irq_q == |(irqStat_q & irqMask_q))
        else $error("interrupt level wrong");

    scan_end_c: cover property (evScanEnd ##1 irqStat_q[IRQ_SCAN_END]);
    wdg_event_c: cover property (evWdg);
    cal_done_c: cover property (calLaunch ##[1:50] calDone);
    read_c: cover property (arTake ##1 rvalid_q);
endmodule

// *** ascr_pkg.sv ***
// shared constants for the scan configuration register bank
package ascr_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] SAMPLE_SEL_OFS = 8'h18;
    localparam logic [7:0] SCAN_MASK_OFS = 8'h1c;
    localparam logic [7:0] WDG_MASK_OFS = 8'h20;
    localparam logic [7:0] WDG_THR_OFS = 8'h28;
    localparam logic [7:0] CAL_FACT_OFS = 8'h30;
    localparam logic [7:0] RESULT_OFS = 8'h40;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h44;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h48;

    localparam logic [31:0] SAMPLE_SEL_RST = 32'h00000000;
    localparam logic [31:0] SCAN_MASK_RST = 32'h00000000;
    localparam logic [31:0] WDG_MASK_RST = 32'h00000000;
    localparam logic [31:0] WDG_THR_RST = 32'h0fff0000;
    localparam logic [31:0] CAL_FACT_RST = 32'h00000000;
    localparam logic [31:0] RESULT_RST = 32'h00000000;
    localparam logic [3:0] IRQ_RST = 4'h0;

    localparam logic [31:0] SAMPLE_SEL_WMASK = 32'h09ffffff;
    localparam logic [31:0] CHAN_WMASK = 32'h0009ffff;
    localparam logic [31:0] WDG_THR_WMASK = 32'h0fff0fff;
    localparam logic [31:0] CAL_WMASK = 32'h0000003f;
    localparam logic [31:0] IRQ_WMASK = 32'h0000000f;

    localparam int FIRST_CODE_LSB = 0;
    localparam int SECOND_CODE_LSB = 4;
    localparam int SEL_LOW_LSB = 8;
    localparam int SEL_LOW_MSB = 24;
    localparam int SEL_CH19_BIT = 27;
    localparam int UPPER_LSB = 16;
    localparam int NUM_CHAN = 20;
    localparam logic [4:0] LAST_CHAN = 5'h13;

    localparam int IRQ_WDG = 0;
    localparam int IRQ_SAMPLE_END = 1;
    localparam int IRQ_SCAN_END = 2;
    localparam int IRQ_CAL_END = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // code 0 is reserved and behaves as the shortest duration
    localparam logic [10:0] SAMPLE_CYCLES_TABLE [0:15] = '{
        11'h003, 11'h003, 11'h007, 11'h00c, 11'h013, 11'h027, 11'h04f, 11'h077,
        11'h09f, 11'h0ef, 11'h13f, 11'h1df, 11'h27f, 11'h3bf, 11'h4ff, 11'h77f
    };
    localparam int CONV_DIV_DEFAULT = 4;
endpackage

// *** ascr_sample_decode.sv ***
// sampling-time code to converter clock cycle count
`timescale 1ns/1ps
module ascr_sample_decode
    import ascr_pkg::*;
(
    input wire logic [3:0] code,
    output logic [10:0] cycles
);
    always_comb
    begin
        cycles = SAMPLE_CYCLES_TABLE[code];
    end
endmodule

// *** ascr_limit_check.sv ***
// watchdog window compare of one result
`timescale 1ns/1ps
module ascr_limit_check
    import ascr_pkg::*;
(
    input wire logic [11:0] value,
    input wire logic [11:0] lower,
    input wire logic [11:0] upper,
    output logic outside
);
    always_comb
    begin
        outside = (value < lower) || (value > upper);
    end
endmodule

// *** adc_scan_config_registers_tb_top.sv ***
// self-checking testbench of the scan configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errCount++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adc_scan_config_registers_tb_top
    import ascr_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic scanStart = 1'b0;
    logic convDone = 1'b0;
    logic [11:0] convData = 12'h000;
    logic calLaunch = 1'b0;
    logic calDone = 1'b0;
    logic [5:0] calResult = 6'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic scanBusy, sampling, convStart, irq;
    logic [4:0] sampleChannel;
    logic [5:0] calFactorApplied;
    int errCount = 0;
    int samplesChecked = 0;
    int seed = 32'he379;
    int cyc [16] = '{3, 3, 7, 12, 19, 39, 79, 119, 159, 239, 319, 479, 639, 959, 1279, 1919};
    logic [7:0] ofs [6] = '{SAMPLE_SEL_OFS, SCAN_MASK_OFS, WDG_MASK_OFS, WDG_THR_OFS,
        CAL_FACT_OFS, IRQ_MASK_OFS};
    logic [31:0] msk [6] = '{32'h09ffffff, 32'h0009ffff, 32'h0009ffff, 32'h0fff0fff,
        32'h0000003f, 32'h0000000f};
    logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h0fff0000, 32'h0, 32'h0};
    logic [31:0] v;
    logic [3:0] c;

    always #25 clk = ~clk;

    ascr_top #(.CONV_DIV(1)) uut (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scanStart(scanStart),
        .convDone(convDone), .convData(convData), .calLaunch(calLaunch), .calDone(calDone),
        .calResult(calResult), .scanBusy(scanBusy), .sampling(sampling),
        .sampleChannel(sampleChannel), .convStart(convStart),
        .calFactorApplied(calFactorApplied), .irq(irq));

    task automatic completeRun;
        begin
            $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
            if (errCount == 0 && samplesChecked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    function automatic int expDur(input logic [3:0] code);
        expDur = (code == 4'h0) ? 3 : cyc[code];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n, dly;
        logic awP, wP, awT, wT;
        begin
            n = 0;
            awP = 1'b1;
            wP = 1'b1;
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            while ((awP || wP) && n < 100)
            begin
                @(negedge clk);
                awT = s_axi_awready;
                wT = s_axi_wready;
                @(posedge clk);
                if (awP && awT === 1'b1)
                begin
                    s_axi_awvalid <= 1'b0;
                    awP = 1'b0;
                end
                if (wP && wT === 1'b1)
                begin
                    s_axi_wvalid <= 1'b0;
                    wP = 1'b0;
                end
                n++;
            end
            dly = $random(seed) & 3;
            repeat (dly) @(posedge clk);
            s_axi_bready <= 1'b1;
            do
            begin
                @(negedge clk);
                n++;
            end while (s_axi_bvalid !== 1'b1 && n < 200);
            `CHK(s_axi_bresp, er)
            @(posedge clk);
            s_axi_bready <= 1'b0;
            if (n >= 200) errCount++;
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n, dly;
        begin
            n = 0;
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do
            begin
                @(negedge clk);
                n++;
            end while (s_axi_arready !== 1'b1 && n < 100);
            @(posedge clk);
            s_axi_arvalid <= 1'b0;
            dly = $random(seed) & 3;
            repeat (dly) @(posedge clk);
            s_axi_rready <= 1'b1;
            do
            begin
                @(negedge clk);
                n++;
            end while (s_axi_rvalid !== 1'b1 && n < 200);
            `CHK(s_axi_rdata, e)
            `CHK(s_axi_rresp, er)
            @(posedge clk);
            s_axi_rready <= 1'b0;
            if (n >= 200) errCount++;
        end
    endtask

    task automatic scanChan(input logic [4:0] ch, input int n, input logic [11:0] d);
        int cnt, k;
        begin
            cnt = 0;
            k = 0;
            while (convStart !== 1'b1 && k < 5000)
            begin
                @(negedge clk);
                if (sampling === 1'b1) cnt++;
                k++;
            end
            `CHK(sampleChannel, ch)
            `CHK((cnt >= n && cnt <= n + 1), 1'b1)
            @(posedge clk);
            convDone <= 1'b1;
            convData <= d;
            @(posedge clk);
            convDone <= 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask

    initial
    begin
        #2000000;
        errCount++;
        completeRun();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 6; i++)
        begin
            rdChk(ofs[i], rstv[i], RESP_OKAY);
            v = $random(seed);
            wr(ofs[i], v, RESP_OKAY);
            rdChk(ofs[i], v & msk[i], RESP_OKAY);
        end
        rdChk(RESULT_OFS, 32'h0, RESP_OKAY);
        wr(RESULT_OFS, v, RESP_OKAY);
        rdChk(RESULT_OFS, 32'h0, RESP_OKAY);
        wr(8'h50, v, RESP_SLVERR);
        rdChk(8'h50, 32'h0, RESP_SLVERR);
        wr(WDG_THR_OFS, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'h4;
        wr(WDG_THR_OFS, 32'hffffffff, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdChk(WDG_THR_OFS, 32'h00ff0000, RESP_OKAY);
        $display("test register access done");
        v = $random(seed);
        wr(CAL_FACT_OFS, {26'h0, v[5:0]}, RESP_OKAY);
        @(negedge clk);
        `CHK(calFactorApplied, 6'h00)
        @(posedge clk);
        calLaunch <= 1'b1;
        @(posedge clk);
        calLaunch <= 1'b0;
        @(negedge clk);
        `CHK(calFactorApplied, v[5:0])
        @(posedge clk);
        calResult <= v[11:6];
        calDone <= 1'b1;
        @(posedge clk);
        calDone <= 1'b0;
        rdChk(CAL_FACT_OFS, {26'h0, v[11:6]}, RESP_OKAY);
        rdChk(RESULT_OFS, {26'h0, v[11:6]}, RESP_OKAY);
        $display("test calibration done");
        c = {2'b00, v[13:12]} + 4'h1;
        wr(IRQ_STAT_OFS, 32'hf, RESP_OKAY);
        wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
        wr(SAMPLE_SEL_OFS, {4'h0, 1'b1, 19'h0, c, 4'h0}, RESP_OKAY);
        wr(SCAN_MASK_OFS, 32'h00080008, RESP_OKAY);
        wr(WDG_MASK_OFS, 32'h00080000, RESP_OKAY);
        wr(WDG_THR_OFS, 32'h08000100, RESP_OKAY);
        @(posedge clk);
        scanStart <= 1'b1;
        @(posedge clk);
        scanStart <= 1'b0;
        scanChan(5'h03, expDur(4'h0), 12'hfff);
        `CHK(irq, 1'b0)
        scanChan(5'h13, expDur(c), 12'h050);
        for (int k = 0; k < 100 && scanBusy === 1'b1; k++) @(negedge clk);
        `CHK(scanBusy, 1'b0)
        `CHK(irq, 1'b1)
        rdChk(RESULT_OFS, 32'h00000050, RESP_OKAY);
        rdChk(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
        wr(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
        rdChk(IRQ_STAT_OFS, 32'h6, RESP_OKAY);
        @(negedge clk);
        `CHK(irq, 1'b0)
        $display("test scan and watchdog done");
        completeRun();
    end
endmodule
